// File: bench/grs_panel_model.sv
`timescale 1ns/10ps
`default_nettype none

module grs_panel_model (
  input wire logic clk_i,
  input wire logic sys_reset_n_o,
  input wire logic sys_reset_n_oe_o,
  input wire logic panel_discharge_n_o,
  input wire logic panel_discharge_n_oe_o,
  output logic rst_line_o,
  output logic xdis_line_o,
  output logic shape_o
);
  logic [4:0] phase_reg = 5'h00;

  // ---------------------------------------------------------------
  // open-drain lines
  // ---------------------------------------------------------------
  // pull-ups win whenever nobody sinks the line
  assign rst_line_o = sys_reset_n_oe_o ? sys_reset_n_o : 1'b1;
  assign xdis_line_o = panel_discharge_n_oe_o ? panel_discharge_n_o : 1'b1;

  // ---------------------------------------------------------------
  // shaping pulses
  // ---------------------------------------------------------------
  // controller pulses only while reset and discharge lines are high, 16 cycles down, 16 up
  always @(posedge clk_i)
  begin
    if (!rst_line_o || !xdis_line_o)
      phase_reg <= 5'h00;
    else
      phase_reg <= phase_reg + 5'h01;
  end
  assign shape_o = phase_reg[4];
endmodule

`default_nettype wire

// File: bench/grs_top_properties.sv
`timescale 1ns/10ps
`default_nettype none

module grs_top_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic vin_above_lockout_i,
  input wire logic vin_above_detect_i,
  input wire logic [3:0] rail_below30_i,
  input wire logic gate_shape_input_i,
  input wire logic logic_rail_en_o,
  input wire logic main_rail_en_o,
  input wire logic neg_rail_en_o,
  input wire logic neg_rail_ramp_o,
  input wire logic neg_rail_discharge_o,
  input wire logic gate_high_en_o,
  input wire logic gate_high_ramp_o,
  input wire logic pass_switch_o,
  input wire logic discharge_switch_a_o,
  input wire logic discharge_switch_b_o,
  input wire logic ground_clamp_switch_o,
  input wire logic sys_reset_n_oe_o,
  input wire logic fault_o
);
  // ---------------------------------------------------------------
  // shared timing
  // ---------------------------------------------------------------
  // one clock domain: clock and reset given once
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // running state: gate-high settled and clamp released
  wire logic in_run = gate_high_en_o && !gate_high_ramp_o
    && !ground_clamp_switch_o;

  // ---------------------------------------------------------------
  // sequencing and protection
  // ---------------------------------------------------------------
  a_gh_after_neg: assert property (
    $rose(gate_high_en_o) |-> neg_rail_en_o && !neg_rail_ramp_o
      && gate_high_ramp_o)
    else $error("gate-high out of order");
  a_lock_rails_off: assert property (
    (!vin_above_lockout_i && !fault_o) [*5] |-> !gate_high_en_o
      && !neg_rail_en_o && neg_rail_discharge_o)
    else $error("rails on in lockout");
  a_fault_all_off: assert property (
    fault_o |-> !(logic_rail_en_o || main_rail_en_o || neg_rail_en_o
      || gate_high_en_o))
    else $error("rail on in fault");
  a_short_fault: assert property (
    in_run && (|rail_below30_i) |-> ##[1:6] fault_o)
    else $error("short not shut down");
  a_fault_latch: assert property (
    fault_o |=> fault_o)
    else $error("fault cleared");
  a_pass_alone: assert property (
    pass_switch_o |-> !(discharge_switch_a_o || discharge_switch_b_o
      || ground_clamp_switch_o))
    else $error("pass closed with another");
  a_shape_fall: assert property (
    in_run && $fell(gate_shape_input_i) |-> ##[1:5]
      (discharge_switch_a_o && discharge_switch_b_o && !pass_switch_o))
    else $error("no discharge after shape fall");
  a_clamp_in_ramp: assert property (
    gate_high_ramp_o |-> ground_clamp_switch_o && !pass_switch_o)
    else $error("no clamp during ramp");
  a_down_pass: assert property (
    main_rail_en_o ##1 (!vin_above_lockout_i && !fault_o) [*5]
      |-> pass_switch_o && !gate_high_en_o)
    else $error("pass open in power-down");
  a_reset_latch: assert property (
    (!sys_reset_n_oe_o && vin_above_lockout_i && vin_above_detect_i)
      [*4] |=> !sys_reset_n_oe_o || fault_o)
    else $error("reset reasserted");

  c_fault: cover property ($rose(fault_o));
  c_run: cover property ($fell(ground_clamp_switch_o) && gate_high_en_o);
  c_down: cover property ($fell(main_rail_en_o) && !fault_o);
endmodule

bind grs_top grs_top_properties i_grs_top_properties (.*);

`default_nettype wire

// File: bench/test_grs_top.sv
`timescale 1ns/10ps
`default_nettype none

module test_grs_top;
  logic clk_i = 0, rst_i = 1, vin_above_lockout_i = 0;
  logic vin_above_detect_i = 0, main_above_uvlo2_i = 1;
  logic logic_rail_good_i = 0, reset_threshold_select_i = 0;
  logic code_wr_i = 0, code_rd_i = 0, gate_shape_input_i;
  logic [3:0] rail_below70_i = 4'h0, rail_below30_i = 4'h0;
  logic [5:0] neg_rail_delay_setting_i = 6'h01;
  logic [5:0] neg_rail_softstart_setting_i = 6'h01;
  logic [5:0] shaping_delay_setting_i = 6'h01;
  logic [7:0] gate_high_softstart_setting_i = 8'h02;
  logic [3:0] reset_pulse_setting_i = 4'h2;
  logic [3:0] neg_rail_target_setting_i = 4'h5;
  logic [3:0] common_upper_limit_i = 4'h9, common_lower_limit_i = 4'h3;
  logic [7:0] code_addr_i = 8'h00, code_wdata_i = 8'h00, code_rdata_o;
  logic [6:0] nv_code_i = 7'h2a, nv_wdata_o, wiper_code_o;
  logic code_rvalid_o, nv_write_o, logic_rail_en_o, main_rail_en_o;
  logic neg_rail_en_o, neg_rail_ramp_o, neg_rail_discharge_o;
  logic gate_high_en_o, gate_high_ramp_o, pass_switch_o, fault_o;
  logic discharge_switch_a_o, discharge_switch_b_o, ground_clamp_switch_o;
  logic sys_reset_n_o, sys_reset_n_oe_o, panel_discharge_n_o;
  logic panel_discharge_n_oe_o, common_enable_o, rst_line_o, xdis_line_o;
  logic [3:0] neg_rail_target_o;
  logic [10:0] common_voltage_code_o;
  logic nv_seen;
  int mismatches = 0, compares = 0, n, rst_cyc, gh_cyc;
  wire [3:0] sw = {pass_switch_o, discharge_switch_a_o,
    discharge_switch_b_o, ground_clamp_switch_o};

  // one millisecond shrinks to 20 cycles
  grs_top #(.US_CYCLES(16'h0002), .MS_US(16'h000a)) i_grs_top (.*);
  grs_panel_model i_grs_panel_model (.*, .shape_o(gate_shape_input_i));

  // ---------------------------------------------------------------
  // clock, store and helpers
  // ---------------------------------------------------------------
  always #2 clk_i = ~clk_i;
  // nonvolatile store takes what the block writes
  always @(posedge clk_i)
    if (nv_write_o)
      nv_code_i <= #1 nv_wdata_o;

  task step(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // bounded wait, a miss counts as a mismatch
  task automatic waitv(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 4000)
    begin
      step(1);
      n++;
    end
    chk(s, v);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    code_addr_i = a;
    code_wdata_i = d;
    code_wr_i = 1;
    step(1);
    nv_seen = nv_write_o;
    code_wr_i = 0;
    step(1);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    code_addr_i = a;
    code_rd_i = 1;
    step(1);
    chk(code_rvalid_o, 1);
    chk(code_rdata_o, e);
    code_rd_i = 0;
    step(1);
  endtask

  // power-on reset, then supplies up until shaping starts
  task boot;
    rst_i = 1;
    logic_rail_good_i = 0;
    {rail_below70_i, rail_below30_i} = 8'h00;
    step(20);
    rst_i = 0;
    step(3);
    vin_above_lockout_i = 1;
    vin_above_detect_i = 1;
    waitv(logic_rail_en_o, 1);
    logic_rail_good_i = 1;
    waitv(sys_reset_n_oe_o, 0);
    rst_cyc = n;
    waitv(gate_high_en_o, 1);
    chk({main_rail_en_o, neg_rail_en_o, neg_rail_ramp_o}, 3'h6);
    waitv(ground_clamp_switch_o, 0);
    gh_cyc = n;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_regs;
    chk(wiper_code_o, 7'h2a);
    main_above_uvlo2_i = 0;
    step(4);
    chk(common_enable_o, 0);
    main_above_uvlo2_i = 1;
    step(4);
    chk(common_enable_o, 1);
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h15);
    chk({nv_seen, wiper_code_o}, {1'b1, 7'h15});
    rd(8'h00, 8'h15);
    wr(8'h01, 8'h80);
    wr(8'h00, 8'h40);
    chk({nv_seen, wiper_code_o, nv_code_i}, 15'h2015);
    step(2);
    chk(common_voltage_code_o, 11'h2fd);
    rd(8'h00, 8'h40);
    rd(8'h01, 8'h80);
    wr(8'h01, 8'h00);
    rd(8'h00, 8'h15);
    rd(8'h7f, 8'h00);
  endtask

  task t_power;
    boot;
    chk(rst_cyc >= 16 && rst_cyc <= 64, 1);
    chk(gh_cyc >= 500 && gh_cyc <= 1100, 1);
    chk({xdis_line_o, neg_rail_target_o}, 5'h15);
    waitv(gate_shape_input_i, 0);
    waitv(gate_shape_input_i, 1);
    step(5);
    chk(sw, 4'h8);
    waitv(gate_shape_input_i, 0);
    step(5);
    chk(sw, 4'h6);
    logic_rail_good_i = 0;
    step(10);
    chk(rst_line_o, 1);
    vin_above_detect_i = 0;
    step(6);
    chk({rst_line_o, xdis_line_o}, 2'h2);
    reset_threshold_select_i = 1;
    step(6);
    chk(rst_line_o, 0);
    vin_above_lockout_i = 0;
    step(6);
    chk({sw, gate_high_en_o, neg_rail_discharge_o}, 6'h21);
  endtask

  task t_fault;
    boot;
    chk(wiper_code_o, 7'h15);
    vin_above_detect_i = 0;
    repeat (2)
    begin
      rail_below70_i = 4'h2;
      step(600);
      rail_below70_i = 4'h0;
      step(4);
    end
    chk(fault_o, 0);
    rail_below70_i = 4'h2;
    step(1100);
    chk({fault_o, main_rail_en_o, gate_high_en_o}, 3'h4);
    rail_below70_i = 4'h0;
    step(40);
    chk(fault_o, 1);
    boot;
    chk(fault_o, 0);
    waitv(gate_shape_input_i, 0);
    rail_below30_i = 4'h8;
    step(6);
    chk({fault_o, neg_rail_en_o, gate_high_en_o}, 3'h4);
  endtask

  task stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    step(20);
    rst_i = 0;
    step(3);
    t_regs;
    $display("t_regs done");
    t_power;
    $display("t_power done");
    t_fault;
    $display("t_fault done");
    stop_test;
  end

  // about three times the expected run
  initial
  begin
    #80000;
    mismatches++;
    stop_test;
  end
endmodule

`default_nettype wire

// File: design/grs_map.vh
// What this block does
// - gate-high stage enables only after negative rail finishes its ramp
// - gate-high soft-start programmable from 0.256 ms to 35 ms
// - input lockout disables gate-high stage without discharging it
// - rail below 70% for over 50 ms shuts the whole device down
// - rail below 30% shuts the device down at once
// - fault shutdown holds until power-on reset
// - negative rail starts 0 to 35 ms after main rail starts
// - negative rail soft-start programmable from 0 to 35 ms
// - negative rail target -5 V to -8 V in 0.2 V steps
// - input lockout disables negative rail and pulls it to ground
// - shaping input high: pass switch closed, other three open
// - shaping input falling edge: pass opens, both discharge switches close
// - power-up: shaped output clamped to ground until shaping delay ends
// - shaping delay 0 to 35 ms counted from gate-high ramp end
// - power-down: pass switch closed, other three open, input ignored
// - panel discharge output low while supply is under detect level
// - reset pulse 0 to 15 ms timed from logic rail ramp end
// - system reset latched high until power-down
// - configuration bit picks lockout or detect as reset threshold
// - common voltage equals lower limit plus span times code over 127
// - only a power-on reset copies the nonvolatile code into the wiper, on the first clock after release
// - access control 00h: writes go to both, reads return store
// - access control 80h: reads and writes touch the wiper only
// - common-voltage function active only while main rail above level
// - system reset goes low below the selected power-down threshold
`ifndef GRS_MAP_VH
`define GRS_MAP_VH

// ----------------------------------------------------------------
// timing base
// ----------------------------------------------------------------
`define GRS_US_CYC 16'h00fa
`define GRS_MS_US 16'h03e8
`define GRS_UV_QUAL_MS 6'h32
`define GRS_DLY_MAX_MS 8'h23
`define GRS_RST_MAX_MS 8'h0f
`define GRS_GH_SS_MIN 8'h01
`define GRS_GH_SS_MAX 8'h88

// ----------------------------------------------------------------
// common-voltage registers
// ----------------------------------------------------------------
`define GRS_ADDR_CODE 8'h00
`define GRS_ADDR_CTRL 8'h01
`define GRS_CTRL_WONLY_BIT 7
`define GRS_CTRL_RST 8'h00
`define GRS_WIPER_RST 7'h00
`define GRS_RD_UNMAPPED 8'h00

`endif

// File: design/grs_span_timer.v
`timescale 1ns/10ps
`default_nettype none

module grs_span_timer (
  input wire clk_i,
  input wire rst_i,
  input wire run_i,
  input wire tick_i,
  input wire [7:0] len_i,
  output wire done_o
);

  reg [7:0] cnt_reg;

  // counts ticks while run is high; a zero length finishes at once
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt_reg <= 8'h00;
    else if (!run_i)
      cnt_reg <= 8'h00;
    else if (tick_i && (cnt_reg < len_i))
      cnt_reg <= cnt_reg + 8'h01;
  end

  assign done_o = run_i && (cnt_reg >= len_i);

endmodule

`default_nettype wire

// File: design/grs_tick_gen.v
`timescale 1ns/10ps
`default_nettype none
`include "grs_map.vh"

module grs_tick_gen #(
  parameter [15:0] US_CYCLES = `GRS_US_CYC,
  parameter [15:0] MS_US = `GRS_MS_US
) (
  input wire clk_i,
  input wire rst_i,
  output reg ms_tick_o,
  output reg sub_tick_o
);

  reg [15:0] cyc_reg;
  reg [15:0] us_reg;
  reg [7:0] sub_reg;
  wire us_tick = (cyc_reg == US_CYCLES - 16'h0001);

  // one prescaler feeds both ticks so every timer shares one time base
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cyc_reg <= 16'h0000;
      us_reg <= 16'h0000;
      sub_reg <= 8'h00;
      ms_tick_o <= 1'b0;
      sub_tick_o <= 1'b0;
    end
    else
    begin
      cyc_reg <= us_tick ? 16'h0000 : cyc_reg + 16'h0001;
      ms_tick_o <= us_tick && (us_reg == MS_US - 16'h0001);
      sub_tick_o <= us_tick && (sub_reg == 8'hff);
      if (us_tick)
      begin
        us_reg <= (us_reg == MS_US - 16'h0001) ? 16'h0000 : us_reg + 16'h0001;
        sub_reg <= sub_reg + 8'h01;
      end
    end
  end

endmodule

`default_nettype wire

// File: design/grs_top.v
`timescale 1ns/10ps
`default_nettype none
`include "grs_map.vh"

module grs_top #(
  parameter [15:0] US_CYCLES = `GRS_US_CYC,
  parameter [15:0] MS_US = `GRS_MS_US
) (
  input wire clk_i,
  input wire rst_i,
  // analog comparators and pins, asynchronous
  input wire vin_above_lockout_i,
  input wire vin_above_detect_i,
  input wire main_above_uvlo2_i,
  input wire logic_rail_good_i,
  input wire [3:0] rail_below70_i,
  input wire [3:0] rail_below30_i,
  input wire gate_shape_input_i,
  // configuration
  input wire [5:0] neg_rail_delay_setting_i,
  input wire [5:0] neg_rail_softstart_setting_i,
  input wire [7:0] gate_high_softstart_setting_i,
  input wire [5:0] shaping_delay_setting_i,
  input wire [3:0] reset_pulse_setting_i,
  input wire [3:0] neg_rail_target_setting_i,
  input wire reset_threshold_select_i,
  input wire [3:0] common_upper_limit_i,
  input wire [3:0] common_lower_limit_i,
  // common-voltage register port
  input wire code_wr_i,
  input wire code_rd_i,
  input wire [7:0] code_addr_i,
  input wire [7:0] code_wdata_i,
  output reg [7:0] code_rdata_o,
  output reg code_rvalid_o,
  // nonvolatile store
  input wire [6:0] nv_code_i,
  output reg nv_write_o,
  output reg [6:0] nv_wdata_o,
  // rail controls
  output reg logic_rail_en_o,
  output reg main_rail_en_o,
  output reg neg_rail_en_o,
  output reg neg_rail_ramp_o,
  output reg neg_rail_discharge_o,
  output reg [3:0] neg_rail_target_o,
  output reg gate_high_en_o,
  output reg gate_high_ramp_o,
  // shaping switches
  output reg pass_switch_o,
  output reg discharge_switch_a_o,
  output reg discharge_switch_b_o,
  output reg ground_clamp_switch_o,
  // open-drain panel pins
  output wire sys_reset_n_o,
  output reg sys_reset_n_oe_o,
  output wire panel_discharge_n_o,
  output reg panel_discharge_n_oe_o,
  // status and common voltage
  output reg fault_o,
  output reg common_enable_o,
  output reg [10:0] common_voltage_code_o,
  output reg [6:0] wiper_code_o
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [9:0] ST_OFF = 10'h001;
  localparam [9:0] ST_LOGIC = 10'h002;
  localparam [9:0] ST_RSTP = 10'h004;
  localparam [9:0] ST_NEGDLY = 10'h008;
  localparam [9:0] ST_NEGSS = 10'h010;
  localparam [9:0] ST_GHSS = 10'h020;
  localparam [9:0] ST_SHDLY = 10'h040;
  localparam [9:0] ST_RUN = 10'h080;
  localparam [9:0] ST_DOWN = 10'h100;
  localparam [9:0] ST_FAULT = 10'h200;

  // clamp a setting into its legal range
  function [7:0] clamp_len;
    input [7:0] val;
    input [7:0] lo;
    input [7:0] hi;
    begin
      if (val < lo)
        clamp_len = lo;
      else if (val > hi)
        clamp_len = hi;
      else
        clamp_len = val;
    end
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  wire [12:0] async_in = {gate_shape_input_i, main_above_uvlo2_i,
    logic_rail_good_i, vin_above_detect_i, vin_above_lockout_i,
    rail_below70_i, rail_below30_i};
  reg [12:0] sync1_reg;
  reg [12:0] sync2_reg;
  reg shape_d_reg;

  // two stages; only the second stage is read by logic
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_reg <= 13'h0000;
      sync2_reg <= 13'h0000;
      shape_d_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
      shape_d_reg <= sync2_reg[12];
    end
  end

  wire [3:0] sc30_s = sync2_reg[3:0];
  wire [3:0] uv70_s = sync2_reg[7:4];
  wire vin_ok = sync2_reg[8];
  wire vin_det = sync2_reg[9];
  wire logic_good = sync2_reg[10];
  wire uvlo2_ok = sync2_reg[11];
  wire shape_s = sync2_reg[12];
  wire shape_fall = shape_d_reg && !shape_s;

  // ----------------------------------------------------------------
  // time base and sequence timers
  // ----------------------------------------------------------------
  wire ms_tick;
  wire sub_tick;
  reg [9:0] st_reg;
  reg [9:0] st_next;
  wire rst_done;
  wire negdly_done;
  wire negss_done;
  wire ghss_done;
  wire shdly_done;

  grs_tick_gen #(
    .US_CYCLES(US_CYCLES),
    .MS_US(MS_US)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ms_tick_o(ms_tick),
    .sub_tick_o(sub_tick)
  );

  // reset pulse timed from the logic rail ramp end
  grs_span_timer u_rst_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(st_reg == ST_RSTP),
    .tick_i(ms_tick),
    .len_i(clamp_len({4'h0, reset_pulse_setting_i}, 8'h00,
      `GRS_RST_MAX_MS)),
    .done_o(rst_done)
  );

  // negative rail start delay after main rail enable
  grs_span_timer u_negdly_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(st_reg == ST_NEGDLY),
    .tick_i(ms_tick),
    .len_i(clamp_len({2'b00, neg_rail_delay_setting_i}, 8'h00,
      `GRS_DLY_MAX_MS)),
    .done_o(negdly_done)
  );

  grs_span_timer u_negss_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(st_reg == ST_NEGSS),
    .tick_i(ms_tick),
    .len_i(clamp_len({2'b00, neg_rail_softstart_setting_i}, 8'h00,
      `GRS_DLY_MAX_MS)),
    .done_o(negss_done)
  );

  // gate-high ramp counts in 256 us steps so 0.256 ms is reachable
  grs_span_timer u_ghss_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(st_reg == ST_GHSS),
    .tick_i(sub_tick),
    .len_i(clamp_len(gate_high_softstart_setting_i, `GRS_GH_SS_MIN,
      `GRS_GH_SS_MAX)),
    .done_o(ghss_done)
  );

  grs_span_timer u_shdly_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(st_reg == ST_SHDLY),
    .tick_i(ms_tick),
    .len_i(clamp_len({2'b00, shaping_delay_setting_i}, 8'h00,
      `GRS_DLY_MAX_MS)),
    .done_o(shdly_done)
  );

  // ----------------------------------------------------------------
  // rail supervision
  // ----------------------------------------------------------------
  // rails: 0 logic, 1 main, 2 negative, 3 gate-high
  wire [3:0] mon;
  wire [3:0] uv_expired;
  wire [3:0] short_hit;
  wire running = (st_reg == ST_RUN);

  assign mon[0] = !(st_reg == ST_OFF || st_reg == ST_LOGIC ||
    st_reg == ST_DOWN || st_reg == ST_FAULT);
  assign mon[1] = (st_reg == ST_NEGSS) || (st_reg == ST_GHSS) ||
    (st_reg == ST_SHDLY) || running;
  assign mon[2] = (st_reg == ST_GHSS) || (st_reg == ST_SHDLY) || running;
  assign mon[3] = (st_reg == ST_SHDLY) || running;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_uv
      reg [5:0] qual_reg;
      // a recovery before expiry restarts the count from zero
      always @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
          qual_reg <= 6'h00;
        else if (!(mon[gi] && uv70_s[gi]))
          qual_reg <= 6'h00;
        else if (ms_tick && (qual_reg <= `GRS_UV_QUAL_MS))
          qual_reg <= qual_reg + 6'h01;
      end
      assign uv_expired[gi] = (qual_reg > `GRS_UV_QUAL_MS);
      assign short_hit[gi] = mon[gi] && sc30_s[gi];
    end
  endgenerate

  wire fault_now = |uv_expired || |short_hit;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // fault beats lockout; only rst_i leaves the fault state
  always @*
  begin
    st_next = st_reg;
    case (st_reg)
      ST_OFF:
        if (vin_ok)
          st_next = ST_LOGIC;
      ST_LOGIC:
        if (logic_good)
          st_next = ST_RSTP;
      ST_RSTP:
        if (rst_done)
          st_next = ST_NEGDLY;
      ST_NEGDLY:
        if (negdly_done)
          st_next = ST_NEGSS;
      ST_NEGSS:
        if (negss_done)
          st_next = ST_GHSS;
      ST_GHSS:
        if (ghss_done)
          st_next = ST_SHDLY;
      ST_SHDLY:
        if (shdly_done)
          st_next = ST_RUN;
      ST_RUN:
        st_next = ST_RUN;
      ST_DOWN:
        if (vin_ok)
          st_next = ST_OFF;
      ST_FAULT:
        st_next = ST_FAULT;
      default:
        st_next = ST_OFF;
    endcase
    if (st_reg != ST_FAULT && st_reg != ST_OFF && st_reg != ST_DOWN)
    begin
      if (fault_now)
        st_next = ST_FAULT;
      else if (!vin_ok)
        st_next = ST_DOWN;
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      st_reg <= ST_OFF;
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // rail enables
  // ----------------------------------------------------------------
  wire live = !(st_next == ST_OFF || st_next == ST_DOWN ||
    st_next == ST_FAULT);
  wire main_on = live && !(st_next == ST_LOGIC || st_next == ST_RSTP);
  wire neg_on = main_on && (st_next != ST_NEGDLY);
  wire gh_on = neg_on && (st_next != ST_NEGSS);

  // lockout drops every stage; only the negative rail is pulled down
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      logic_rail_en_o <= 1'b0;
      main_rail_en_o <= 1'b0;
      neg_rail_en_o <= 1'b0;
      neg_rail_ramp_o <= 1'b0;
      neg_rail_discharge_o <= 1'b1;
      neg_rail_target_o <= 4'h0;
      gate_high_en_o <= 1'b0;
      gate_high_ramp_o <= 1'b0;
      fault_o <= 1'b0;
    end
    else
    begin
      logic_rail_en_o <= live;
      main_rail_en_o <= main_on;
      neg_rail_en_o <= neg_on;
      neg_rail_ramp_o <= (st_next == ST_NEGSS);
      neg_rail_discharge_o <= !neg_on;
      neg_rail_target_o <= neg_rail_target_setting_i;
      gate_high_en_o <= gh_on;
      gate_high_ramp_o <= (st_next == ST_GHSS);
      fault_o <= (st_next == ST_FAULT);
    end
  end

  // ----------------------------------------------------------------
  // gate voltage shaping
  // ----------------------------------------------------------------
  reg dis_reg;
  reg dis_next;

  // discharge starts on a falling edge and ends when the input rises
  always @*
  begin
    dis_next = 1'b0;
    if (st_next == ST_RUN)
    begin
      if (st_reg != ST_RUN)
        dis_next = !shape_s;
      else if (shape_s)
        dis_next = 1'b0;
      else if (shape_fall)
        dis_next = 1'b1;
      else
        dis_next = dis_reg;
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dis_reg <= 1'b0;
      pass_switch_o <= 1'b0;
      discharge_switch_a_o <= 1'b0;
      discharge_switch_b_o <= 1'b0;
      ground_clamp_switch_o <= 1'b1;
    end
    else
    begin
      dis_reg <= dis_next;
      if (st_next == ST_RUN)
      begin
        pass_switch_o <= shape_s;
        discharge_switch_a_o <= dis_next;
        discharge_switch_b_o <= dis_next;
        ground_clamp_switch_o <= 1'b0;
      end
      else if (st_next == ST_DOWN)
      begin
        pass_switch_o <= 1'b1;
        discharge_switch_a_o <= 1'b0;
        discharge_switch_b_o <= 1'b0;
        ground_clamp_switch_o <= 1'b0;
      end
      else
      begin
        pass_switch_o <= 1'b0;
        discharge_switch_a_o <= 1'b0;
        discharge_switch_b_o <= 1'b0;
        ground_clamp_switch_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // system reset and panel discharge pins
  // ----------------------------------------------------------------
  reg rst_high_reg;
  wire below_sel = reset_threshold_select_i ? !vin_det : !vin_ok;

  // once released the reset stays high until the supply falls away
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rst_high_reg <= 1'b0;
      sys_reset_n_oe_o <= 1'b1;
      panel_discharge_n_oe_o <= 1'b1;
    end
    else
    begin
      if (below_sel)
        rst_high_reg <= 1'b0;
      else if ((st_reg == ST_RSTP) && rst_done)
        rst_high_reg <= 1'b1;
      sys_reset_n_oe_o <= below_sel ||
        !(rst_high_reg || ((st_reg == ST_RSTP) && rst_done));
      panel_discharge_n_oe_o <= !vin_det;
    end
  end

  // open-drain: the pins only ever drive low
  assign sys_reset_n_o = 1'b0;
  assign panel_discharge_n_o = 1'b0;

  // ----------------------------------------------------------------
  // common-voltage code registers
  // ----------------------------------------------------------------
  reg [7:0] access_reg;
  reg copied_reg;
  wire wiper_only = access_reg[`GRS_CTRL_WONLY_BIT];
  wire [3:0] span = (common_upper_limit_i > common_lower_limit_i) ?
    common_upper_limit_i - common_lower_limit_i : 4'h0;

  // the power-up copy runs on the first edge after reset release
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      access_reg <= `GRS_CTRL_RST;
      copied_reg <= 1'b0;
      wiper_code_o <= `GRS_WIPER_RST;
      nv_write_o <= 1'b0;
      nv_wdata_o <= `GRS_WIPER_RST;
      code_rdata_o <= 8'h00;
      code_rvalid_o <= 1'b0;
    end
    else
    begin
      nv_write_o <= 1'b0;
      code_rvalid_o <= code_rd_i;
      if (!copied_reg)
      begin
        copied_reg <= 1'b1;
        wiper_code_o <= nv_code_i;
      end
      else if (code_wr_i && (code_addr_i == `GRS_ADDR_CODE))
      begin
        wiper_code_o <= code_wdata_i[6:0];
        nv_write_o <= !wiper_only;
        nv_wdata_o <= code_wdata_i[6:0];
      end
      if (code_wr_i && (code_addr_i == `GRS_ADDR_CTRL))
        access_reg <= code_wdata_i;
      if (code_rd_i)
      begin
        if (code_addr_i == `GRS_ADDR_CODE)
          code_rdata_o <= {1'b0, wiper_only ? wiper_code_o : nv_code_i};
        else if (code_addr_i == `GRS_ADDR_CTRL)
          code_rdata_o <= access_reg;
        else
          code_rdata_o <= `GRS_RD_UNMAPPED;
      end
    end
  end

  // level in 1/127 steps of the limit unit; a bad span reads as zero
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      common_enable_o <= 1'b0;
      common_voltage_code_o <= 11'h000;
    end
    else
    begin
      common_enable_o <= uvlo2_ok;
      common_voltage_code_o <= {common_lower_limit_i, 7'h00} -
        {7'h00, common_lower_limit_i} + {4'h0, wiper_code_o} *
        {7'h00, span};
    end
  end

endmodule

`default_nettype wire
